//--- common/nbx_pkg.sv
package nbx_pkg;

  // register byte offsets on the avalon slave
  localparam logic [7:0] OFF_INSTR = 8'h00;
  localparam logic [7:0] OFF_CORE = 8'h04;
  localparam logic [7:0] OFF_PC = 8'h08;
  localparam logic [7:0] OFF_TIMER = 8'h0c;
  localparam logic [7:0] OFF_STATUS = 8'h10;
  localparam logic [7:0] OFF_GPR = 8'h80;

  // field positions
  localparam int CORE_CRY_BIT = 4;
  localparam int CORE_F_BIT = 5;
  localparam int CORE_PAGE_LSB = 8;
  localparam int CORE_SLOW_BIT = 12;
  localparam int INSTR_W1_LSB = 16;
  localparam int PC_PAGE_BIT = 10;
  localparam int PC_RAS_LSB = 16;
  localparam int PC_STK_BIT = 28;
  localparam int TMR_CNT_LSB = 16;
  localparam int TMR_STAT_BIT = 31;
  localparam int STAT_HALT_BIT = 0;
  localparam int STAT_IRST_BIT = 1;
  localparam int STAT_WAKE_LSB = 4;

  // reset values and counts
  localparam logic [9:0] PC_RST = 10'h000;
  localparam logic [9:0] TMR_RST = 10'h000;
  localparam logic [3:0] ACC_RST = 4'h0;
  localparam logic [7:0] TMR_DIV_FAST = 8'h40;
  localparam logic [7:0] TMR_DIV_SLOW = 8'h80;
  localparam logic [9:0] ALL_ONES_ACC = 10'h00f;

  // fixed opcodes
  localparam logic [9:0] OPC_NOP = 10'h000;
  localparam logic [9:0] OPC_HALT = 10'h051;
  localparam logic [9:0] OPC_STAT_IMM = 10'h071;
  localparam logic [9:0] OPC_CALL = 10'h0d2;
  localparam logic [9:0] OPC_RET = 10'h112;
  localparam logic [9:0] OPC_JMP0 = 10'h111;
  localparam logic [9:0] OPC_JMP1 = 10'h131;
  localparam logic [9:0] OPC_JCY0 = 10'h191;
  localparam logic [9:0] OPC_JCY1 = 10'h151;
  localparam logic [9:0] OPC_JNCY0 = 10'h1b1;
  localparam logic [9:0] OPC_JNCY1 = 10'h171;
  localparam logic [9:0] OPC_JFL0 = 10'h1d1;
  localparam logic [9:0] OPC_JFL1 = 10'h211;
  localparam logic [9:0] OPC_JNFL0 = 10'h1f1;
  localparam logic [9:0] OPC_JNFL1 = 10'h231;
  localparam logic [9:0] OPC_ONES = 10'h353;
  localparam logic [9:0] OPC_LDT10 = 10'h0df;
  localparam logic [9:0] OPC_LDTTBL = 10'h0ff;
  localparam logic [9:0] OPC_RDT0 = 10'h3df;
  localparam logic [9:0] OPC_RDT1 = 10'h3ff;
  localparam logic [9:0] OPC_WRT0 = 10'h09f;
  localparam logic [9:0] OPC_WRT1 = 10'h0bf;
  // pattern groups: opcode masked must equal base
  localparam logic [9:0] MSK_MOVRA = 10'h3d0;
  localparam logic [9:0] BAS_MOVRA = 10'h080;
  localparam logic [9:0] MSK_NIB = 10'h3f0;
  localparam logic [9:0] BAS_LDI8 = 10'h030;
  localparam logic [9:0] BAS_LDTBL = 10'h020;
  localparam logic [9:0] BAS_STATR = 10'h010;

  typedef enum logic [2:0] {
    ST_IDLE, ST_EXEC, ST_ROM, ST_CALL2, ST_ACK
  } nbx_state_t;

  typedef enum logic [4:0] {
    OP_NOP, OP_MOVRA, OP_LDI8, OP_LDTBL, OP_JMP, OP_JCY, OP_JNCY, OP_JFL,
    OP_JNFL, OP_CALL, OP_RET, OP_RDT, OP_WRT, OP_LDT10, OP_LDTTBL,
    OP_HALT, OP_STATR, OP_STATI, OP_ONES
  } nbx_op_t;

  // operand word a9 a7 a6 a5 a4 a8 a3..a0 to a9..a0
  function automatic logic [9:0] jaddr(input logic [9:0] w);
    return {w[9], w[4], w[8:5], w[3:0]};
  endfunction

  function automatic nbx_op_t decode(input logic [9:0] w);
    nbx_op_t op;
    op = OP_NOP;
    if ((w & MSK_MOVRA) == BAS_MOVRA) op = OP_MOVRA;
    else if ((w & MSK_NIB) == BAS_LDI8) op = OP_LDI8;
    else if ((w & MSK_NIB) == BAS_LDTBL && w[3:0] != 4'h0) op = OP_LDTBL;
    else if ((w & MSK_NIB) == BAS_STATR) op = OP_STATR;
    else if (w == OPC_JMP0 || w == OPC_JMP1) op = OP_JMP;
    else if (w == OPC_JCY0 || w == OPC_JCY1) op = OP_JCY;
    else if (w == OPC_JNCY0 || w == OPC_JNCY1) op = OP_JNCY;
    else if (w == OPC_JFL0 || w == OPC_JFL1) op = OP_JFL;
    else if (w == OPC_JNFL0 || w == OPC_JNFL1) op = OP_JNFL;
    else if (w == OPC_CALL) op = OP_CALL;
    else if (w == OPC_RET) op = OP_RET;
    else if (w == OPC_RDT0 || w == OPC_RDT1) op = OP_RDT;
    else if (w == OPC_WRT0 || w == OPC_WRT1) op = OP_WRT;
    else if (w == OPC_LDT10) op = OP_LDT10;
    else if (w == OPC_LDTTBL) op = OP_LDTTBL;
    else if (w == OPC_HALT) op = OP_HALT;
    else if (w == OPC_STAT_IMM) op = OP_STATI;
    else if (w == OPC_ONES) op = OP_ONES;
    return op;
  endfunction

endpackage

//--- core/nbx_exec_core.sv
// Functional notes
// - accumulator to any register, one cycle
// - data8 high nibble high bank, low low
// - table read into pair one to F
// - 1K pages, page count per variant
// - jump loads all ten pc bits
// - operand word bits are scrambled order
// - carry jumps, else pc plus two
// - test flag jumps, else pc plus two
// - call: stack up, save, then jump
// - stack pointer carry on call resets
// - return restores pc, then stack down
// - stack pointer borrow on return resets
// - timer nibble read, carry cleared
// - timer nibble write clears bit 1 (high nibble) or bit 0 (low nibble)
// - immediate load fills all timer bits
// - interval is value plus one times divider
// - table timer load from rom word
// - standby entry with release conditions
// - status test sets flag on match
// - carry set only when accumulator all ones
//
// The implementer's own choices: the address map and the Avalon-MM slave port.
`timescale 1ns/100ps
module nbx_exec_core #(
  parameter int NUM_PAGES = 2,
  parameter int STK_W = 1
) (
  input wire logic core_clk_i,
  input wire logic nrst_i,
  input wire logic [7:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0] avs_byteenable_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  output logic [10:0] rom_addr_o,
  output logic rom_rd_o,
  input wire logic [9:0] rom_data_i,
  input wire logic select_input_a_i,
  input wire logic select_input_b_i,
  input wire logic key_io_status_i,
  input wire logic key_input_status_i,
  output logic standby_o,
  output logic [3:0] wake_cond_o,
  output logic int_reset_o
);

  nbx_pkg::nbx_state_t state_reg;
  nbx_pkg::nbx_op_t op;
  logic [9:0] instr0_reg;
  logic [9:0] instr1_reg;
  logic [31:0] rdata_reg;
  logic [3:0] acc_reg;
  logic carry_flag_reg;
  logic test_flag_reg;
  logic [9:0] pc_reg;
  logic page_reg;
  logic [STK_W-1:0] stack_pointer_reg;
  logic [10:0] return_address_holder_reg;
  logic standby_reg;
  logic [3:0] wake_reg;
  logic irst_evt_reg;
  logic int_reset_reg;
  logic [2:0] rom_page_select_reg;
  logic slow_reg;
  logic [3:0] gpr_reg [32];
  logic [9:0] tmr_reg;
  logic [9:0] cnt_reg;
  logic [7:0] pre_reg;
  logic tmr_stat_reg;
  logic [3:0] sync1_reg;
  logic [3:0] sync2_reg;
  logic [10:0] rom_addr_reg;
  logic rom_rd_reg;
  logic [3:0] st_vec;
  logic [9:0] tgt;
  logic tgt_page;
  logic two_word;
  logic [9:0] pc_seq;
  logic [STK_W:0] stk_inc;
  logic [STK_W:0] stk_dec;
  logic stk_ovf;
  logic stk_unf;
  logic [3:0] nib;
  logic [4:0] gidx;
  logic bus_hit_gpr;
  logic bus_wr;
  logic [31:0] bmask;
  logic [31:0] rd_mux;
  logic [31:0] wv;
  logic tmr_load;
  logic [9:0] tmr_load_val;
  logic tick;
  logic [7:0] div;

  // two-flop synchronisers for the status pins
  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      sync1_reg <= 4'h0;
      sync2_reg <= 4'h0;
    end else begin
      sync1_reg <= {key_input_status_i, key_io_status_i,
                    select_input_b_i, select_input_a_i};
      sync2_reg <= sync1_reg;
    end
  end

  // status vector: a, b, any key, timer
  assign st_vec = {tmr_stat_reg, sync2_reg[3] | sync2_reg[2],
                   sync2_reg[1], sync2_reg[0]};

  // instruction decode and sequencing terms
  assign op = nbx_pkg::decode(instr0_reg);
  assign tgt = nbx_pkg::jaddr(instr1_reg);
  assign nib = instr0_reg[3:0];
  assign stk_inc = {1'b0, stack_pointer_reg} + (STK_W+1)'(1);
  assign stk_dec = {1'b0, stack_pointer_reg} - (STK_W+1)'(1);
  assign stk_ovf = stk_inc[STK_W];
  assign stk_unf = stk_dec[STK_W];
  assign pc_seq = pc_reg + (two_word ? 10'h002 : 10'h001);

  // page of a jump target, clipped to the fitted rom
  always_comb begin
    tgt_page = 1'b0;
    if (NUM_PAGES > 1) begin
      tgt_page = (instr0_reg == nbx_pkg::OPC_JMP1) ||
                 (instr0_reg == nbx_pkg::OPC_JCY1) ||
                 (instr0_reg == nbx_pkg::OPC_JNCY1) ||
                 (instr0_reg == nbx_pkg::OPC_JFL1) ||
                 (instr0_reg == nbx_pkg::OPC_JNFL1);
    end
  end

  // instructions that carry a second word
  always_comb begin
    case (op)
      nbx_pkg::OP_LDI8, nbx_pkg::OP_JMP, nbx_pkg::OP_JCY,
      nbx_pkg::OP_JNCY, nbx_pkg::OP_JFL, nbx_pkg::OP_JNFL,
      nbx_pkg::OP_CALL, nbx_pkg::OP_LDT10, nbx_pkg::OP_HALT,
      nbx_pkg::OP_STATI: two_word = 1'b1;
      default: two_word = 1'b0;
    endcase
  end

  // bus decode, byte lane merge and read mux
  assign bus_hit_gpr = avs_address_i[7];
  assign gidx = avs_address_i[6:2];
  assign bus_wr = (state_reg == nbx_pkg::ST_ACK) && avs_write_i;
  assign bmask = {{8{avs_byteenable_i[3]}}, {8{avs_byteenable_i[2]}},
                  {8{avs_byteenable_i[1]}}, {8{avs_byteenable_i[0]}}};
  assign wv = (rd_mux & ~bmask) | (avs_writedata_i & bmask);

  always_comb begin
    rd_mux = 32'h0;
    if (bus_hit_gpr) begin
      rd_mux[3:0] = gpr_reg[gidx];
    end else begin
      case (avs_address_i)
        nbx_pkg::OFF_INSTR: begin
          rd_mux[9:0] = instr0_reg;
          rd_mux[nbx_pkg::INSTR_W1_LSB +: 10] = instr1_reg;
        end
        nbx_pkg::OFF_CORE: begin
          rd_mux[3:0] = acc_reg;
          rd_mux[nbx_pkg::CORE_CRY_BIT] = carry_flag_reg;
          rd_mux[nbx_pkg::CORE_F_BIT] = test_flag_reg;
          rd_mux[nbx_pkg::CORE_PAGE_LSB +: 3] = rom_page_select_reg;
          rd_mux[nbx_pkg::CORE_SLOW_BIT] = slow_reg;
        end
        nbx_pkg::OFF_PC: begin
          rd_mux[9:0] = pc_reg;
          rd_mux[nbx_pkg::PC_PAGE_BIT] = page_reg;
          rd_mux[nbx_pkg::PC_RAS_LSB +: 11] = return_address_holder_reg;
          rd_mux[nbx_pkg::PC_STK_BIT +: STK_W] = stack_pointer_reg;
        end
        nbx_pkg::OFF_TIMER: begin
          rd_mux[9:0] = tmr_reg;
          rd_mux[nbx_pkg::TMR_CNT_LSB +: 10] = cnt_reg;
          rd_mux[nbx_pkg::TMR_STAT_BIT] = tmr_stat_reg;
        end
        nbx_pkg::OFF_STATUS: begin
          rd_mux[nbx_pkg::STAT_HALT_BIT] = standby_reg;
          rd_mux[nbx_pkg::STAT_IRST_BIT] = irst_evt_reg;
          rd_mux[nbx_pkg::STAT_WAKE_LSB +: 4] = wake_reg;
        end
        default: rd_mux = 32'h0;
      endcase
    end
  end

  // sequencer: bus handshake and instruction steps
  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      state_reg <= nbx_pkg::ST_IDLE;
      instr0_reg <= nbx_pkg::OPC_NOP;
      instr1_reg <= nbx_pkg::OPC_NOP;
      rdata_reg <= 32'h0;
    end else begin
      case (state_reg)
        nbx_pkg::ST_IDLE: begin
          if (avs_write_i && !bus_hit_gpr &&
              avs_address_i == nbx_pkg::OFF_INSTR && !standby_reg) begin
            instr0_reg <= avs_writedata_i[9:0];
            instr1_reg <= avs_writedata_i[nbx_pkg::INSTR_W1_LSB +: 10];
            state_reg <= nbx_pkg::ST_EXEC;
          end else if (avs_read_i || avs_write_i) begin
            rdata_reg <= rd_mux;
            state_reg <= nbx_pkg::ST_ACK;
          end
        end
        nbx_pkg::ST_EXEC: begin
          if (op == nbx_pkg::OP_LDTBL || op == nbx_pkg::OP_LDTTBL)
            state_reg <= nbx_pkg::ST_ROM;
          else if (op == nbx_pkg::OP_CALL && !stk_ovf)
            state_reg <= nbx_pkg::ST_CALL2;
          else
            state_reg <= nbx_pkg::ST_ACK;
        end
        nbx_pkg::ST_ROM: state_reg <= nbx_pkg::ST_ACK;
        nbx_pkg::ST_CALL2: state_reg <= nbx_pkg::ST_ACK;
        nbx_pkg::ST_ACK: state_reg <= nbx_pkg::ST_IDLE;
        default: state_reg <= nbx_pkg::ST_IDLE;
      endcase
    end
  end

  assign avs_waitrequest_o = (state_reg != nbx_pkg::ST_ACK);
  assign avs_readdata_o = rdata_reg;

  // table address: page select on top, pair zero below
  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rom_addr_reg <= 11'h000;
      rom_rd_reg <= 1'b0;
    end else begin
      rom_rd_reg <= 1'b0;
      if (state_reg == nbx_pkg::ST_EXEC &&
          (op == nbx_pkg::OP_LDTBL || op == nbx_pkg::OP_LDTTBL)) begin
        rom_addr_reg <= {rom_page_select_reg, gpr_reg[16],
                         gpr_reg[0]};
        rom_rd_reg <= 1'b1;
      end
    end
  end

  assign rom_addr_o = rom_addr_reg;
  assign rom_rd_o = rom_rd_reg;

  // cpu state: accumulator, flags, pc, stack, standby
  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      acc_reg <= nbx_pkg::ACC_RST;
      carry_flag_reg <= 1'b0;
      test_flag_reg <= 1'b0;
      pc_reg <= nbx_pkg::PC_RST;
      page_reg <= 1'b0;
      stack_pointer_reg <= '0;
      return_address_holder_reg <= 11'h000;
      standby_reg <= 1'b0;
      wake_reg <= 4'h0;
      irst_evt_reg <= 1'b0;
      int_reset_reg <= 1'b0;
      rom_page_select_reg <= 3'h0;
      slow_reg <= 1'b0;
    end else begin
      int_reset_reg <= 1'b0;
      if (state_reg == nbx_pkg::ST_EXEC) begin
        pc_reg <= pc_seq;
        case (op)
          nbx_pkg::OP_JMP: begin
            pc_reg <= tgt;
            page_reg <= tgt_page;
          end
          nbx_pkg::OP_JCY: if (carry_flag_reg) begin
            pc_reg <= tgt;
            page_reg <= tgt_page;
          end
          nbx_pkg::OP_JNCY: if (!carry_flag_reg) begin
            pc_reg <= tgt;
            page_reg <= tgt_page;
          end
          nbx_pkg::OP_JFL: if (test_flag_reg) begin
            pc_reg <= tgt;
            page_reg <= tgt_page;
          end
          nbx_pkg::OP_JNFL: if (!test_flag_reg) begin
            pc_reg <= tgt;
            page_reg <= tgt_page;
          end
          nbx_pkg::OP_CALL: begin
            stack_pointer_reg <= stk_inc[STK_W-1:0];
            return_address_holder_reg <= {page_reg, pc_seq};
            if (stk_ovf) begin
              pc_reg <= nbx_pkg::PC_RST;
              page_reg <= 1'b0;
              stack_pointer_reg <= '0;
              int_reset_reg <= 1'b1;
            end
          end
          nbx_pkg::OP_RET: begin
            pc_reg <= return_address_holder_reg[9:0];
            page_reg <= return_address_holder_reg[10];
            stack_pointer_reg <= stk_dec[STK_W-1:0];
            if (stk_unf) begin
              pc_reg <= nbx_pkg::PC_RST;
              page_reg <= 1'b0;
              stack_pointer_reg <= '0;
              int_reset_reg <= 1'b1;
            end
          end
          nbx_pkg::OP_RDT: begin
            acc_reg <= instr0_reg[5] ? tmr_reg[9:6] : tmr_reg[5:2];
            carry_flag_reg <= 1'b0;
          end
          nbx_pkg::OP_HALT: begin
            standby_reg <= 1'b1;
            wake_reg <= instr1_reg[3:0];
          end
          nbx_pkg::OP_STATR: test_flag_reg <= |(st_vec & gpr_reg[nib]);
          nbx_pkg::OP_STATI:
            test_flag_reg <= |(st_vec & instr1_reg[3:0]);
          nbx_pkg::OP_ONES:
            carry_flag_reg <= ({6'h00, acc_reg} == nbx_pkg::ALL_ONES_ACC);
          default: ;
        endcase
      end else if (state_reg == nbx_pkg::ST_CALL2) begin
        pc_reg <= tgt;
        page_reg <= tgt_page;
      end else if (bus_wr && !bus_hit_gpr) begin
        if (avs_address_i == nbx_pkg::OFF_CORE) begin
          acc_reg <= wv[3:0];
          carry_flag_reg <= wv[nbx_pkg::CORE_CRY_BIT];
          test_flag_reg <= wv[nbx_pkg::CORE_F_BIT];
          rom_page_select_reg <= wv[nbx_pkg::CORE_PAGE_LSB +: 3];
          slow_reg <= wv[nbx_pkg::CORE_SLOW_BIT];
        end
        if (avs_address_i == nbx_pkg::OFF_STATUS &&
            wv[nbx_pkg::STAT_HALT_BIT] && avs_byteenable_i[0])
          standby_reg <= 1'b0;
      end
      // sticky internal reset event, set wins over clear
      if (state_reg == nbx_pkg::ST_EXEC &&
          ((op == nbx_pkg::OP_CALL && stk_ovf) ||
           (op == nbx_pkg::OP_RET && stk_unf)))
        irst_evt_reg <= 1'b1;
      else if (bus_wr && !bus_hit_gpr &&
               avs_address_i == nbx_pkg::OFF_STATUS &&
               avs_byteenable_i[0] && avs_writedata_i[nbx_pkg::STAT_IRST_BIT])
        irst_evt_reg <= 1'b0;
    end
  end

  assign standby_o = standby_reg;
  assign wake_cond_o = wake_reg;
  assign int_reset_o = int_reset_reg;

  // general registers: two banks of sixteen nibbles
  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      for (int i = 0; i < 32; i++) gpr_reg[i] <= 4'h0;
    end else begin
      if (state_reg == nbx_pkg::ST_EXEC && op == nbx_pkg::OP_MOVRA) begin
        gpr_reg[{instr0_reg[5], nib}] <= acc_reg;
      end else if (state_reg == nbx_pkg::ST_EXEC &&
                   op == nbx_pkg::OP_LDI8) begin
        gpr_reg[{1'b1, nib}] <= instr1_reg[7:4];
        gpr_reg[{1'b0, nib}] <= instr1_reg[3:0];
      end else if (state_reg == nbx_pkg::ST_ROM &&
                   op == nbx_pkg::OP_LDTBL) begin
        gpr_reg[{1'b1, nib}] <= rom_data_i[7:4];
        gpr_reg[{1'b0, nib}] <= rom_data_i[3:0];
      end else if (bus_wr && bus_hit_gpr) begin
        gpr_reg[gidx] <= wv[3:0];
      end
    end
  end

  // timer loads from accumulator, immediate or table
  always_comb begin
    tmr_load = 1'b0;
    tmr_load_val = tmr_reg;
    if (state_reg == nbx_pkg::ST_EXEC && op == nbx_pkg::OP_WRT) begin
      tmr_load = 1'b1;
      if (instr0_reg[5])
        tmr_load_val = {acc_reg, tmr_reg[5:2], 1'b0, tmr_reg[0]};
      else
        tmr_load_val = {tmr_reg[9:6], acc_reg, tmr_reg[1], 1'b0};
    end else if (state_reg == nbx_pkg::ST_EXEC &&
                 op == nbx_pkg::OP_LDT10) begin
      tmr_load = 1'b1;
      tmr_load_val = instr1_reg;
    end else if (state_reg == nbx_pkg::ST_ROM &&
                 op == nbx_pkg::OP_LDTTBL) begin
      tmr_load = 1'b1;
      tmr_load_val = rom_data_i;
    end
  end

  // interval = (value + 1) x 64 or 128 clocks
  assign div = slow_reg ? nbx_pkg::TMR_DIV_SLOW : nbx_pkg::TMR_DIV_FAST;
  assign tick = (pre_reg == div - 8'h01);

  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      tmr_reg <= nbx_pkg::TMR_RST;
      cnt_reg <= nbx_pkg::TMR_RST;
      pre_reg <= 8'h00;
      tmr_stat_reg <= 1'b0;
    end else if (tmr_load) begin
      tmr_reg <= tmr_load_val;
      cnt_reg <= tmr_load_val;
      pre_reg <= 8'h00;
      tmr_stat_reg <= 1'b0;
    end else begin
      pre_reg <= tick ? 8'h00 : pre_reg + 8'h01;
      if (tick) begin
        if (cnt_reg == 10'h000) begin
          cnt_reg <= tmr_reg;
          tmr_stat_reg <= 1'b1;
        end else begin
          cnt_reg <= cnt_reg - 10'h001;
        end
      end
    end
  end

endmodule // nbx_exec_core

//--- dv/nbx_exec_core_properties.sv
`timescale 1ns/100ps
module nbx_exec_core_properties #(
  parameter int NUM_PAGES = 2,
  parameter int STK_W = 1
) (
  input wire logic core_clk_i,
  input wire logic nrst_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic avs_waitrequest_o,
  input wire logic [10:0] rom_addr_o,
  input wire logic rom_rd_o,
  input wire logic standby_o,
  input wire logic [3:0] wake_cond_o,
  input wire logic int_reset_o
);
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!nrst_i);
  // bus answer shape
  a_ack_single: assert property (
    !avs_waitrequest_o |=> avs_waitrequest_o)
    else $error("answer held longer than one cycle");
  a_ack_needs_req: assert property (
    !avs_waitrequest_o |-> avs_read_i || avs_write_i)
    else $error("answer without request");
  a_ack_bound: assert property (
    (avs_read_i || avs_write_i) && avs_waitrequest_o
    |-> ##[1:3] !avs_waitrequest_o)
    else $error("answer later than three cycles");
  // rom fetch shape
  a_rom_pulse: assert property (
    rom_rd_o |=> !rom_rd_o)
    else $error("rom read longer than one cycle");
  a_rom_then_ack: assert property (
    rom_rd_o |=> !avs_waitrequest_o)
    else $error("no answer after rom fetch");
  a_rom_addr_held: assert property (
    $changed(rom_addr_o) |-> rom_rd_o && avs_write_i)
    else $error("rom address moved without a fetch");
  // stack faults
  a_irst_with_ack: assert property (
    int_reset_o |-> !avs_waitrequest_o ##1 !int_reset_o)
    else $error("internal reset not a single answered pulse");
  // standby entry
  a_standby_by_write: assert property (
    $rose(standby_o) |-> avs_write_i)
    else $error("standby entered without a write");
  a_wake_with_halt: assert property (
    !$stable(wake_cond_o) |-> $rose(standby_o))
    else $error("wake condition changed outside halt");
endmodule // nbx_exec_core_properties

bind nbx_exec_core nbx_exec_core_properties #(
  .NUM_PAGES(NUM_PAGES),
  .STK_W(STK_W)
) chk_u (
  .core_clk_i(core_clk_i),
  .nrst_i(nrst_i),
  .avs_read_i(avs_read_i),
  .avs_write_i(avs_write_i),
  .avs_waitrequest_o(avs_waitrequest_o),
  .rom_addr_o(rom_addr_o),
  .rom_rd_o(rom_rd_o),
  .standby_o(standby_o),
  .wake_cond_o(wake_cond_o),
  .int_reset_o(int_reset_o)
);

//--- dv/nbx_rom_model.sv
`timescale 1ns/100ps
module nbx_rom_model (
  input wire logic core_clk_i,
  input wire logic [10:0] rom_addr_i,
  input wire logic rom_rd_i,
  output logic [9:0] rom_data_o
);
  logic [9:0] last_q = 10'h000;
  // scrambled word while read, inverse of last word otherwise
  always_comb rom_data_o = rom_rd_i ? rom_addr_i[9:0] ^ 10'h2a5
    : ~last_q;
  // last driven value, so idle data keeps toggling
  always @(posedge core_clk_i) last_q <= rom_data_o;
endmodule // nbx_rom_model

//--- dv/nbx_exec_core_tb.sv
`timescale 1ns/100ps
module nbx_exec_core_tb;
  logic core_clk_i = 1'b0;
  logic nrst_i = 1'b0;
  logic [7:0] avs_address_i = 8'h00;
  logic avs_read_i = 1'b0;
  logic avs_write_i = 1'b0;
  logic [31:0] avs_writedata_i = 32'h0;
  logic [31:0] avs_readdata_o;
  logic avs_waitrequest_o;
  logic [10:0] rom_addr_o;
  logic rom_rd_o;
  logic [9:0] rom_data_i;
  logic [3:0] sin = 4'h0;
  logic standby_o;
  logic [3:0] wake_cond_o;
  logic int_reset_o;
  logic [31:0] q;
  logic [31:0] p;
  int bad_count = 0;
  int comparisons = 0;
  int cyc = 0;
  int tb0;
  int e;
  logic [9:0] jop [8];
  // clock and cycle count
  always #2.5 core_clk_i = ~core_clk_i;
  always @(posedge core_clk_i) cyc <= cyc + 1;
  nbx_exec_core dut_u (
    .core_clk_i(core_clk_i), .nrst_i(nrst_i),
    .avs_address_i(avs_address_i), .avs_read_i(avs_read_i),
    .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
    .avs_byteenable_i(4'hf), .avs_readdata_o(avs_readdata_o),
    .avs_waitrequest_o(avs_waitrequest_o), .rom_addr_o(rom_addr_o),
    .rom_rd_o(rom_rd_o), .rom_data_i(rom_data_i),
    .select_input_a_i(sin[0]), .select_input_b_i(sin[1]),
    .key_io_status_i(sin[2]), .key_input_status_i(sin[3]),
    .standby_o(standby_o), .wake_cond_o(wake_cond_o),
    .int_reset_o(int_reset_o));
  nbx_rom_model rom_u (.core_clk_i(core_clk_i), .rom_addr_i(rom_addr_o),
    .rom_rd_i(rom_rd_o), .rom_data_o(rom_data_i));
  // verdict and end of run
  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] x,
    input logic [31:0] g);
    comparisons++;
    if (g !== x) begin
      bad_count++;
      $display("unexpected %s expected %h seen %h", nm, x, g);
    end
  endtask
  // one avalon transfer, held until waitrequest low
  task automatic bus(input logic w, input logic [7:0] a,
    input logic [31:0] d);
    int n;
    n = 0;
    @(posedge core_clk_i);
    avs_address_i <= a;
    avs_writedata_i <= d;
    avs_write_i <= w;
    avs_read_i <= ~w;
    do begin
      @(posedge core_clk_i);
      n++;
    end while (avs_waitrequest_o !== 1'b0 && n < 40);
    q = avs_readdata_o;
    avs_write_i <= 1'b0;
    avs_read_i <= 1'b0;
    if (n >= 40) begin
      bad_count++;
      complete_run();
    end
  endtask
  task automatic ex(input logic [9:0] w0, input logic [9:0] w1);
    bus(1'b1, nbx_pkg::OFF_INSTR, {6'h00, w1, 6'h00, w0});
  endtask
  task automatic setc(input logic [3:0] a, input logic c, input logic f,
    input logic [2:0] pg, input logic s);
    bus(1'b1, nbx_pkg::OFF_CORE, {19'h0, s, 1'b0, pg, 2'h0, f, c, a});
  endtask
  initial begin
    jop = '{nbx_pkg::OPC_JCY0, nbx_pkg::OPC_JCY1, nbx_pkg::OPC_JNCY0,
      nbx_pkg::OPC_JNCY1, nbx_pkg::OPC_JFL0, nbx_pkg::OPC_JFL1,
      nbx_pkg::OPC_JNFL0, nbx_pkg::OPC_JNFL1};
    repeat (16) @(posedge core_clk_i);
    nrst_i <= 1'b1;
    setc(4'h5, 1'b0, 1'b0, 3'h0, 1'b0);
    ex(10'h0a3, 10'h000);
    bus(1'b0, 8'hcc, 32'h0);
    chk("high reg 3", 32'h5, q & 32'hf);
    bus(1'b0, nbx_pkg::OFF_CORE, 32'h0);
    chk("acc kept", 32'h5, q & 32'h1f);
    ex(10'h030, 10'h037);
    setc(4'h0, 1'b0, 1'b0, 3'h3, 1'b0);
    ex(10'h025, 10'h000);
    bus(1'b0, 8'hd4, 32'h0);
    chk("high reg 5", 32'h9, q & 32'hf);
    bus(1'b0, 8'h94, 32'h0);
    chk("low reg 5", 32'h2, q & 32'hf);
    ex(nbx_pkg::OPC_LDTTBL, 10'h000);
    bus(1'b0, nbx_pkg::OFF_TIMER, 32'h0);
    chk("table timer", 32'h192, q & 32'h3ff);
    for (int k = 0; k < 16; k++) begin
      for (int c = 0; c < 2; c++) begin
        setc(4'h0, k[2] ? 1'b0 : c[0], k[2] ? c[0] : 1'b0, 3'h0, 1'b0);
        ex(nbx_pkg::OPC_JMP0, 10'h008);
        ex(jop[k[2:0]], 10'h210);
        bus(1'b0, nbx_pkg::OFF_PC, 32'h0);
        e = (c[0] == ~k[1]) ? {k[0], 10'h300} : 32'h00a;
        chk("jump pc", e, q & 32'h7ff);
      end
    end
    ex(nbx_pkg::OPC_JMP1, 10'h210);
    bus(1'b0, nbx_pkg::OFF_PC, 32'h0);
    chk("page jump", 32'h700, q & 32'h7ff);
    ex(nbx_pkg::OPC_JMP0, 10'h008);
    ex(nbx_pkg::OPC_CALL, 10'h210);
    bus(1'b0, nbx_pkg::OFF_PC, 32'h0);
    chk("call", 32'h100a0300, q);
    ex(nbx_pkg::OPC_RET, 10'h000);
    bus(1'b0, nbx_pkg::OFF_PC, 32'h0);
    chk("return", 32'h000a000a, q);
    for (int u = 0; u < 2; u++) begin
      if (u == 0) begin
        ex(nbx_pkg::OPC_RET, 10'h000);
      end else begin
        ex(nbx_pkg::OPC_CALL, 10'h008);
        ex(nbx_pkg::OPC_CALL, 10'h210);
      end
      bus(1'b0, nbx_pkg::OFF_PC, 32'h0);
      chk("stack fault pc", 32'h0, q & 32'h100007ff);
      bus(1'b0, nbx_pkg::OFF_STATUS, 32'h0);
      chk("stack fault flag", 32'h2, q & 32'h2);
      bus(1'b1, nbx_pkg::OFF_STATUS, 32'h2);
    end
    for (int i = 0; i < 4; i++) begin
      sin <= 4'h1 << i;
      repeat (3) @(posedge core_clk_i);
      ex(nbx_pkg::OPC_STAT_IMM, 10'h001 << (i < 2 ? i : 2));
      bus(1'b0, nbx_pkg::OFF_CORE, 32'h0);
      chk("status match", 32'h20, q & 32'h20);
      ex(nbx_pkg::OPC_STAT_IMM, i == 0 ? 10'h002 : 10'h001);
      bus(1'b0, nbx_pkg::OFF_CORE, 32'h0);
      chk("status miss", 32'h0, q & 32'h20);
      ex(10'h010, 10'h000);
      bus(1'b0, nbx_pkg::OFF_CORE, 32'h0);
      chk("status reg match", 32'h20, q & 32'h20);
    end
    for (int a = 0; a < 16; a++) begin
      setc(a[3:0], a != 15, 1'b0, 3'h0, 1'b0);
      ex(nbx_pkg::OPC_ONES, 10'h000);
      bus(1'b0, nbx_pkg::OFF_CORE, 32'h0);
      chk("all ones carry", a == 15 ? 32'h10 : 32'h0, q & 32'h10);
    end
    ex(nbx_pkg::OPC_LDT10, 10'h2b7);
    setc(4'h0, 1'b1, 1'b0, 3'h0, 1'b0);
    ex(nbx_pkg::OPC_RDT1, 10'h000);
    bus(1'b0, nbx_pkg::OFF_CORE, 32'h0);
    chk("timer high read", 32'h0a, q & 32'h1f);
    ex(nbx_pkg::OPC_RDT0, 10'h000);
    bus(1'b0, nbx_pkg::OFF_CORE, 32'h0);
    chk("timer low read", 32'h0d, q & 32'h1f);
    setc(4'h3, 1'b0, 1'b0, 3'h0, 1'b0);
    ex(nbx_pkg::OPC_WRT1, 10'h000);
    bus(1'b0, nbx_pkg::OFF_TIMER, 32'h0);
    chk("timer high write", 32'h0f5, q & 32'h3ff);
    setc(4'h0, 1'b0, 1'b0, 3'h0, 1'b0);
    ex(nbx_pkg::OPC_WRT0, 10'h000);
    bus(1'b0, nbx_pkg::OFF_TIMER, 32'h0);
    chk("timer low write", 32'h0c0, q & 32'h3ff);
    for (int s = 0; s < 2; s++) begin
      setc(4'h0, 1'b0, 1'b0, 3'h0, s[0]);
      ex(nbx_pkg::OPC_LDT10, s ? 10'h000 : 10'h002);
      tb0 = cyc;
      q = 32'h0;
      for (int n = 0; n < 100 && q[31] !== 1'b1; n++) begin
        bus(1'b0, nbx_pkg::OFF_TIMER, 32'h0);
      end
      e = (cyc - tb0) - (s ? 128 : 192);
      chk("interval ok", 32'h1, 32'(e > -8 && e < 8));
    end
    bus(1'b0, nbx_pkg::OFF_PC, 32'h0);
    p = q;
    ex(nbx_pkg::OPC_HALT, 10'h006);
    chk("standby", 32'h16, {27'h0, standby_o, wake_cond_o});
    bus(1'b0, nbx_pkg::OFF_PC, 32'h0);
    p = q;
    ex(nbx_pkg::OPC_JMP0, 10'h210);
    bus(1'b0, nbx_pkg::OFF_PC, 32'h0);
    chk("refused in standby", p, q);
    bus(1'b1, nbx_pkg::OFF_STATUS, 32'h1);
    @(posedge core_clk_i);
    chk("standby cleared", 32'h0, {31'h0, standby_o});
    complete_run();
  end
endmodule // nbx_exec_core_tb
